// >>> rtl/hub_string_descriptor_config_regs.sv
`timescale 1ns/10ps
`include "hsd_params.svh"
module hub_string_descriptor_config_regs #(
    parameter int SER_BYTES = 32, // serial byte registers
    parameter int TXT_BYTES = 64  // maker and product byte registers
) (
    input  wire logic              clock, // 10 MHz system clock
    input  wire logic              sys_rst, // sync reset, active high
    input  wire hsd_pkg::hsd_mode_t cfgMode, // current configuration mode
    input  wire logic              i2cLoadDone, // eeprom load finished, pulse
    input  wire logic              customTextEnable, // custom_text_enable setting
    input  wire logic              customSerialEnable, // custom_serial_enable setting
    input  wire logic              ssSuspendPin, // pin sampled for spread disable
    input  wire logic [255:0]      fuseSerial, // die id derived serial bytes
    input  wire logic              regWrite, // register write strobe
    input  wire logic [7:0]        regAddr, // register offset
    input  wire logic [7:0]        regWdata, // write data
    output logic [7:0]             regRdata, // read data, registered
    input  wire logic [1:0]        strIndex, // string descriptor index
    input  wire logic [6:0]        strByte, // byte within string
    output logic [7:0]             strData, // descriptor byte, registered
    output logic [6:0]             strLength, // bytes in selected string, registered
    output logic                   ssSpreadDisable, // ss_spread_disable
    output logic                   configurationHold, // upstream connect blocked
    output logic                   sidebandPortReset // smbus slave reset request
);
    import hsd_pkg::*;
    if (SER_BYTES != 32 || TXT_BYTES != 64) begin : g_bad_size
        $error("byte counts fixed by the map");
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] langLow, langHigh, rsv2f, rsvF1, rsvF2;
    logic [5:0] serLen;
    logic [6:0] makLen, prdLen;
    logic [7:0] serBytes [SER_BYTES];
    logic [7:0] makBytes [TXT_BYTES];
    logic [7:0] prdBytes [TXT_BYTES];
    logic       ssSusSync;
    logic [1:0] spreadSettle;
    hsd_state_t state;
    logic [3:0] rstCount;
    hsd_sync2 u_sus (
        .clock   (clock),
        .sys_rst (sys_rst),
        .din     (ssSuspendPin),
        .dout    (ssSusSync)
    );
    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire        modeCfg   = (cfgMode == HSD_MODE_I2C) || (cfgMode == HSD_MODE_SMBUS);
    wire        wrEn      = regWrite && modeCfg && state != HSD_SBRST;
    wire        hitSer    = regAddr >= `HSD_OFF_SER_BASE && regAddr <= `HSD_OFF_SER_LAST;
    wire        hitMak    = regAddr >= `HSD_OFF_MAK_BASE && regAddr <= `HSD_OFF_MAK_LAST;
    wire        hitPrd    = regAddr >= `HSD_OFF_PRD_BASE && regAddr <= `HSD_OFF_PRD_LAST;
    wire [4:0]  serIdx    = 5'(regAddr - `HSD_OFF_SER_BASE);
    wire [5:0]  makIdx    = 6'(regAddr - `HSD_OFF_MAK_BASE);
    wire [5:0]  prdIdx    = 6'(regAddr - `HSD_OFF_PRD_BASE);
    wire        langWr    = wrEn && customTextEnable;
    wire        serWr     = wrEn && customSerialEnable && hitSer;
    wire        softReset = state == HSD_SBRST && rstCount == `HSD_RST_CYCLES;
    wire        clearAll  = sys_rst || softReset;
    wire        statusWr  = wrEn && regAddr == `HSD_OFF_STATUS;
    // ----------------------------------------
    // configuration bytes
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (clearAll) begin
            langLow  <= `HSD_RST_LANG_LO;
            langHigh <= `HSD_RST_LANG_HI;
            serLen   <= `HSD_RST_SER_LEN;
            makLen   <= '0;
            prdLen   <= '0;
            rsv2f    <= '0;
            rsvF1    <= '0;
            rsvF2    <= '0;
        end else if (wrEn) begin
            if (langWr && regAddr == `HSD_OFF_LANG_LO) langLow <= regWdata;
            if (langWr && regAddr == `HSD_OFF_LANG_HI) langHigh <= regWdata;
            // lengths beyond the byte array would leak past the string
            if (regAddr == `HSD_OFF_SER_LEN && {2'b00, regWdata[5:0]} <= {1'b0, `HSD_MAX_SER_LEN})
                serLen <= regWdata[5:0];
            if (regAddr == `HSD_OFF_MAK_LEN && regWdata[6:0] <= `HSD_MAX_TXT_LEN)
                makLen <= regWdata[6:0];
            if (regAddr == `HSD_OFF_PRD_LEN && regWdata[6:0] <= `HSD_MAX_TXT_LEN)
                prdLen <= regWdata[6:0];
            if (regAddr == `HSD_OFF_RSV_2F) rsv2f <= regWdata & `HSD_MASK_BIT0;
            if (regAddr == `HSD_OFF_RSV_F1) rsvF1 <= regWdata & `HSD_MASK_F1;
            if (regAddr == `HSD_OFF_RSV_F2) rsvF2 <= regWdata & `HSD_MASK_BIT0;
        end
    end
    // ----------------------------------------
    // spread disable: pin sampled after reset release, then writable
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (clearAll) begin
            ssSpreadDisable <= 1'b0;
            spreadSettle    <= '0;
        end else if (spreadSettle < `HSD_SUS_SETTLE) begin
            // the synchroniser is cleared by reset, so wait until the pin level has crossed it
            spreadSettle    <= spreadSettle + 2'h1;
        end else if (spreadSettle == `HSD_SUS_SETTLE) begin
            ssSpreadDisable <= ssSusSync;
            spreadSettle    <= spreadSettle + 2'h1;
        end else if (wrEn && regAddr == `HSD_OFF_EXTRA) begin
            ssSpreadDisable <= regWdata[0];
        end
    end
    // ----------------------------------------
    // string byte arrays
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (clearAll) begin
            for (int i = 0; i < SER_BYTES; i++) serBytes[i] <= fuseSerial[i*8 +: 8];
            for (int i = 0; i < TXT_BYTES; i++) begin
                makBytes[i] <= '0;
                prdBytes[i] <= '0;
            end
        end else begin
            if (serWr) serBytes[serIdx] <= regWdata;
            if (wrEn && hitMak) makBytes[makIdx] <= regWdata;
            if (wrEn && hitPrd) prdBytes[prdIdx] <= regWdata;
        end
    end
    // ----------------------------------------
    // configuration hold and sideband reset sequencer
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state             <= HSD_IDLE;
            configurationHold <= 1'b0;
            sidebandPortReset <= 1'b0;
            rstCount          <= '0;
        end else begin
            case (state)
                HSD_IDLE: begin
                    if (modeCfg) begin
                        configurationHold <= 1'b1;
                        state             <= HSD_HOLD;
                    end
                end
                HSD_HOLD: begin
                    if (cfgMode == HSD_MODE_I2C && i2cLoadDone) begin
                        configurationHold <= 1'b0;
                    end else if (statusWr && regWdata[0]) begin
                        configurationHold <= 1'b0;
                    end
                    if (statusWr && regWdata[1] && cfgMode == HSD_MODE_SMBUS) begin
                        sidebandPortReset <= 1'b1;
                        rstCount          <= '0;
                        state             <= HSD_SBRST;
                    end else if (!modeCfg) begin
                        configurationHold <= 1'b0;
                        state             <= HSD_IDLE;
                    end
                end
                HSD_SBRST: begin
                    rstCount <= rstCount + 4'h1;
                    if (softReset) begin
                        sidebandPortReset <= 1'b0;
                        state             <= HSD_HOLD;
                    end
                end
                default: state <= HSD_IDLE;
            endcase
        end
    end
    // ----------------------------------------
    // register read path
    // ----------------------------------------
    logic [7:0] rdMux;
    always_comb begin
        rdMux = 8'h00;
        case (regAddr)
            `HSD_OFF_LANG_LO: rdMux = langLow;
            `HSD_OFF_LANG_HI: rdMux = langHigh;
            `HSD_OFF_SER_LEN: rdMux = {2'b00, serLen};
            `HSD_OFF_MAK_LEN: rdMux = {1'b0, makLen};
            `HSD_OFF_PRD_LEN: rdMux = {1'b0, prdLen};
            `HSD_OFF_RSV_2F:  rdMux = rsv2f;
            `HSD_OFF_EXTRA:   rdMux = {7'h00, ssSpreadDisable};
            `HSD_OFF_RSV_F1:  rdMux = rsvF1;
            `HSD_OFF_RSV_F2:  rdMux = rsvF2;
            `HSD_OFF_STATUS:  rdMux = {6'h00, sidebandPortReset, configurationHold};
            default: begin
                if (hitSer) rdMux = serBytes[serIdx];
                else if (hitMak) rdMux = makBytes[makIdx];
                else if (hitPrd) rdMux = prdBytes[prdIdx];
                else rdMux = 8'h00;
            end
        endcase
    end
    // ----------------------------------------
    // descriptor byte path
    // ----------------------------------------
    logic [7:0] dMux;
    logic [6:0] lMux;
    always_comb begin
        dMux = 8'h00;
        lMux = 7'h00;
        case (strIndex)
            `HSD_IDX_LANG: begin
                lMux = 7'h02;
                dMux = strByte[0] ? langHigh : langLow;
            end
            `HSD_IDX_SER: begin
                lMux = {1'b0, serLen};
                if (strByte < lMux) dMux = serBytes[strByte[4:0]];
            end
            `HSD_IDX_PRD: begin
                lMux = prdLen;
                if (strByte < lMux) dMux = prdBytes[strByte[5:0]];
            end
            `HSD_IDX_MAK: begin
                lMux = makLen;
                if (strByte < lMux) dMux = makBytes[strByte[5:0]];
            end
            default: dMux = 8'h00;
        endcase
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            regRdata  <= '0;
            strData   <= '0;
            strLength <= '0;
        end else begin
            regRdata  <= rdMux;
            strData   <= dMux;
            strLength <= lMux;
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_rst_req;
        statusWr && regWdata[1] && cfgMode == HSD_MODE_SMBUS && state == HSD_HOLD;
    endsequence
    a_lang_reset: assert property (@(posedge clock) $fell(sys_rst) |-> langLow == `HSD_RST_LANG_LO
        && langHigh == `HSD_RST_LANG_HI) else $error("language reset wrong");
    a_lang_gate: assert property (@(posedge clock) disable iff (sys_rst)
        !customTextEnable && !softReset |=> $stable(langLow)) else $error("language written while locked");
    a_serlen_max: assert property (@(posedge clock) disable iff (sys_rst)
        {1'b0, serLen} <= `HSD_MAX_SER_LEN) else $error("serial length too long");
    a_txt_max: assert property (@(posedge clock) disable iff (sys_rst)
        makLen <= `HSD_MAX_TXT_LEN && prdLen <= `HSD_MAX_TXT_LEN) else $error("text length too long");
    a_reserved_config_2f_zero: assert property (@(posedge clock) disable iff (sys_rst)
        (rsvF1 & ~`HSD_MASK_F1) == 8'h00 && rsv2f[7:1] == 7'h00) else $error("reserved bit set");
    a_ser_gate: assert property (@(posedge clock) disable iff (sys_rst)
        !customSerialEnable && !softReset |=> $stable(serBytes[0])) else $error("serial written locked");
    a_hold_entry: assert property (@(posedge clock) disable iff (sys_rst)
        state == HSD_IDLE && modeCfg |=> configurationHold) else $error("hold not set");
    a_sb_reset: assert property (@(posedge clock) disable iff (sys_rst)
        s_rst_req |=> sidebandPortReset [*5] ##1 !sidebandPortReset) else $error("reset length wrong");
    a_hold_clear: assert property (@(posedge clock) disable iff (sys_rst)
        state == HSD_HOLD && statusWr && regWdata[0] |=> !configurationHold) else $error("hold not cleared");
    a_unmapped: assert property (@(posedge clock) disable iff (sys_rst)
        regAddr == 8'h25 |=> regRdata == 8'h00) else $error("unmapped read nonzero");
endmodule : hub_string_descriptor_config_regs

// >>> rtl/hsd_params.svh
`ifndef HSD_PARAMS_SVH
`define HSD_PARAMS_SVH
`define HSD_OFF_LANG_LO   8'h20
`define HSD_OFF_LANG_HI   8'h21
`define HSD_OFF_SER_LEN   8'h22
`define HSD_OFF_MAK_LEN   8'h23
`define HSD_OFF_PRD_LEN   8'h24
`define HSD_OFF_RSV_2F    8'h2f
`define HSD_OFF_SER_BASE  8'h30
`define HSD_OFF_SER_LAST  8'h4f
`define HSD_OFF_MAK_BASE  8'h50
`define HSD_OFF_MAK_LAST  8'h8f
`define HSD_OFF_PRD_BASE  8'h90
`define HSD_OFF_PRD_LAST  8'hcf
`define HSD_OFF_EXTRA     8'hf0
`define HSD_OFF_RSV_F1    8'hf1
`define HSD_OFF_RSV_F2    8'hf2
`define HSD_OFF_STATUS    8'hf8
`define HSD_RST_LANG_LO   8'h09
`define HSD_RST_LANG_HI   8'h04
`define HSD_RST_SER_LEN   6'h14
`define HSD_MAX_SER_LEN   7'h20
`define HSD_MAX_TXT_LEN   7'h40
`define HSD_MASK_F1       8'hc1
`define HSD_MASK_BIT0     8'h01
`define HSD_IDX_LANG      2'h0
`define HSD_IDX_SER       2'h1
`define HSD_IDX_PRD       2'h2
`define HSD_IDX_MAK       2'h3
`define HSD_RST_CYCLES    4'h4
`define HSD_SUS_SETTLE    2'h2
`endif

// >>> rtl/hsd_pkg.sv
package hsd_pkg;
    typedef enum logic [1:0] {HSD_MODE_PIN, HSD_MODE_I2C, HSD_MODE_SMBUS} hsd_mode_t;
    typedef enum {HSD_IDLE, HSD_HOLD, HSD_SBRST} hsd_state_t;
endpackage : hsd_pkg

// >>> rtl/hsd_sync2.sv
`timescale 1ns/10ps
module hsd_sync2 (
    input  wire logic clock, // system clock
    input  wire logic sys_rst, // sync reset
    input  wire logic din, // async level
    output logic      dout // synchronised level
);
    logic stage1;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule : hsd_sync2

// >>> verification/hsd_host_model.sv
`timescale 1ns/10ps
// ------------------------------------
// sideband host on the register port
// ------------------------------------
module hsd_host_model (
    input  wire logic       clock,    // system clock
    output logic            regWrite, // write strobe
    output logic [7:0]      regAddr,  // offset
    output logic [7:0]      regWdata, // write data
    input  wire logic [7:0] regRdata  // registered read data
);
    initial begin
        regWrite = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
    end
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
        // released data flips so a stale byte can never look like a write
        regWdata <= ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        @(posedge clock);
        #1;
        d = regRdata;
    endtask : read_reg
    // text bytes are handed in already as utf-16le pairs
    task automatic park_zero(input logic [7:0] a);
        write_reg(a, 8'h00);
    endtask : park_zero
    task automatic clear_hold();
        write_reg(8'hf8, 8'h01);
    endtask : clear_hold
endmodule : hsd_host_model

// >>> verification/hub_string_descriptor_config_regs_test.sv
`timescale 1ns/10ps
module hub_string_descriptor_config_regs_test;
    import hsd_pkg::*;
    logic         clock;
    logic         sys_rst;
    hsd_mode_t    cfgMode;
    logic         i2cLoadDone;
    logic         customTextEnable;
    logic         customSerialEnable;
    logic         ssSuspendPin;
    logic [255:0] fuseSerial;
    logic         regWrite;
    logic [7:0]   regAddr;
    logic [7:0]   regWdata;
    logic [7:0]   regRdata;
    logic [1:0]   strIndex;
    logic [6:0]   strByte;
    logic [7:0]   strData;
    logic [6:0]   strLength;
    logic         ssSpreadDisable;
    logic         configurationHold;
    logic         sidebandPortReset;
    int           numErrors = 0;
    int           checked = 0;
    // ----------------
    // instances
    // ----------------
    hub_string_descriptor_config_regs dut (.clock(clock), .sys_rst(sys_rst), .cfgMode(cfgMode),
        .i2cLoadDone(i2cLoadDone), .customTextEnable(customTextEnable), .customSerialEnable(customSerialEnable),
        .ssSuspendPin(ssSuspendPin), .fuseSerial(fuseSerial), .regWrite(regWrite), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .strIndex(strIndex), .strByte(strByte), .strData(strData),
        .strLength(strLength), .ssSpreadDisable(ssSpreadDisable), .configurationHold(configurationHold),
        .sidebandPortReset(sidebandPortReset));
    hsd_host_model host (.clock(clock), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata));
    // ----------------
    // helpers
    // ----------------
    function automatic logic [7:0] fuse_byte(input int n);
        return 8'h80 + n[7:0];
    endfunction : fuse_byte
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            numErrors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8
    task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        check8(d, exp);
    endtask : reg_is
    task automatic wr_is(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        host.write_reg(a, d);
        reg_is(a, exp);
    endtask : wr_is
    task automatic str_is(input logic [1:0] i, input logic [6:0] b, input logic [7:0] d, input logic [6:0] n);
        @(posedge clock);
        strIndex <= i;
        strByte  <= b;
        @(posedge clock);
        #1;
        check8(strData, d);
        check8({1'b0, strLength}, {1'b0, n});
    endtask : str_is
    task automatic report_and_stop();
        if (numErrors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    // ----------------
    // scenarios
    // ----------------
    task automatic test_reset();
        reg_is(8'h20, 8'h09);
        reg_is(8'h21, 8'h04);
        reg_is(8'h22, 8'h14);
        reg_is(8'h23, 8'h00);
        reg_is(8'h24, 8'h00);
        reg_is(8'hf0, 8'h01);
        reg_is(8'h25, 8'h00);
        for (int i = 0; i < 32; i++) reg_is(8'h30 + i[7:0], fuse_byte(i));
        str_is(2'h0, 7'h01, 8'h04, 7'h02);
        str_is(2'h1, 7'h13, fuse_byte(19), 7'h14);
        str_is(2'h1, 7'h14, 8'h00, 7'h14);
        str_is(2'h3, 7'h00, 8'h00, 7'h00);
        wr_is(8'h23, 8'h05, 8'h00);
    endtask : test_reset
    task automatic test_smbus();
        logic [7:0] rsv [4] = '{8'h2f, 8'hf1, 8'hf2, 8'hf0};
        logic [7:0] msk [4] = '{8'h01, 8'hc1, 8'h01, 8'h01};
        @(posedge clock);
        cfgMode <= HSD_MODE_SMBUS;
        repeat (2) @(posedge clock);
        #1;
        check8(configurationHold, 8'h01);
        wr_is(8'h20, 8'h55, 8'h09);
        wr_is(8'h30, 8'haa, fuse_byte(0));
        @(posedge clock);
        customTextEnable   <= 1'b1;
        customSerialEnable <= 1'b1;
        wr_is(8'h20, 8'h55, 8'h55);
        wr_is(8'h4f, 8'haa, 8'haa);
        wr_is(8'h22, 8'h21, 8'h14);
        wr_is(8'h22, 8'h20, 8'h20);
        wr_is(8'h23, 8'h41, 8'h00);
        wr_is(8'h23, 8'h40, 8'h40);
        wr_is(8'h24, 8'h40, 8'h40);
        for (int i = 0; i < 4; i++) wr_is(rsv[i], 8'hff, msk[i]);
        check8(ssSpreadDisable, 8'h01);
        for (int i = 0; i < 4; i++) host.park_zero(rsv[i]);
        wr_is(8'hd0, 8'hff, 8'h00);
        wr_is(8'h8f, 8'h33, 8'h33);
        wr_is(8'hcf, 8'h44, 8'h44);
        host.write_reg(8'h50, 8'h41);
        host.write_reg(8'h52, 8'h7a);
        host.write_reg(8'h23, 8'h02);
        host.write_reg(8'h90, 8'h50);
        host.write_reg(8'h24, 8'h01);
        str_is(2'h3, 7'h00, 8'h41, 7'h02);
        str_is(2'h3, 7'h02, 8'h00, 7'h02);
        str_is(2'h2, 7'h00, 8'h50, 7'h01);
    endtask : test_smbus
    task automatic test_sideband();
        host.write_reg(8'hf8, 8'h02);
        #1;
        check8(sidebandPortReset, 8'h01);
        // bounded wait: the reset is a few cycles long
        for (int n = 0; n < 20 && sidebandPortReset === 1'b1; n++) @(posedge clock);
        #1;
        check8(sidebandPortReset, 8'h00);
        reg_is(8'h20, 8'h09);
        reg_is(8'hf8, 8'h01);
        wr_is(8'hf8, 8'h00, 8'h01);
        host.clear_hold();
        reg_is(8'hf8, 8'h00);
        check8(configurationHold, 8'h00);
    endtask : test_sideband
    task automatic test_i2c();
        @(posedge clock);
        cfgMode <= HSD_MODE_PIN;
        repeat (2) @(posedge clock);
        cfgMode <= HSD_MODE_I2C;
        repeat (2) @(posedge clock);
        #1;
        check8(configurationHold, 8'h01);
        wr_is(8'h21, 8'h12, 8'h12);
        @(posedge clock);
        i2cLoadDone <= 1'b1;
        @(posedge clock);
        i2cLoadDone <= 1'b0;
        @(posedge clock);
        #1;
        check8(configurationHold, 8'h00);
    endtask : test_i2c
    // ----------------
    // clock, watchdog, main
    // ----------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // whole run is well under a thousand cycles
    initial begin
        #500000;
        numErrors++;
        report_and_stop();
    end
    initial begin
        sys_rst            = 1'b1;
        cfgMode            = HSD_MODE_PIN;
        i2cLoadDone        = 1'b0;
        customTextEnable   = 1'b0;
        customSerialEnable = 1'b0;
        ssSuspendPin       = 1'b1;
        strIndex           = 2'h0;
        strByte            = 7'h00;
        for (int i = 0; i < 32; i++) fuseSerial[i*8 +: 8] = fuse_byte(i);
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
        test_reset();
        test_smbus();
        test_sideband();
        test_i2c();
        report_and_stop();
    end
endmodule : hub_string_descriptor_config_regs_test
